// File: logic/uarx_rx.sv
// Asynchronous receive front end with start detect, voting, filter and FIFO
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------------
// Receive buffer FIFO
// ----------------------------------------------------------------------------
module uarx_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   // Handshakes and honest full/empty
   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   // Pointer and count update
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // Storage, written only on accepted push
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule

// ----------------------------------------------------------------------------
// Receiver top
// ----------------------------------------------------------------------------
module uarx_rx
   import uarx_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   input  wire logic                     rx_serial_in,
   input  wire logic                     sample_tick,
   input  wire logic                     double_speed_sel,
   input  wire logic                     sync_mode,
   input  wire logic                     multiproc_filter_en,
   input  wire logic [3:0]               data_bits,
   input  wire logic                     parity_en,
   output logic                          rx_valid,
   input  wire logic                     rx_ready,
   output logic      [DATA_BITS_MAX-1:0] rx_data,
   output logic                          rx_parity,
   output logic                          frame_error_flag,
   output logic                          frame_lost
);
   uarx_state_t                state;
   uarx_state_t                next_state;
   logic                       sync_a;
   logic                       sync_b;
   logic                       next_sync_a;
   logic                       next_sync_b;
   logic [3:0]                 samp;
   logic [3:0]                 next_samp;
   logic [3:0]                 bit_idx;
   logic [3:0]                 next_bit_idx;
   logic [2:0]                 votes;
   logic [2:0]                 next_votes;
   logic [DATA_BITS_MAX-1:0]   shreg;
   logic [DATA_BITS_MAX-1:0]   next_shreg;
   logic                       par;
   logic                       next_par;
   logic                       lost;
   logic                       next_lost;
   logic                       fifo_in_valid;
   logic                       fifo_in_ready;
   logic [WORD_W:0]            fifo_in_data;
   logic [WORD_W:0]            fifo_out_data;
   logic                       dbl;
   logic [3:0]                 vote_first;
   logic [3:0]                 last_samp;
   logic                       in_vote;
   logic                       vote_bit;
   logic [3:0]                 frame_bits;
   logic                       stop_bit;
   logic                       addr_flag;
   logic                       keep_frame;
   logic                       prev_hi;
   logic                       next_prev_hi;

   // ----------------------------------------------------------------------------
   // Line synchroniser and mode decode
   // ----------------------------------------------------------------------------
   // Two-flop synchroniser: next values
   always_comb begin
      next_sync_a = rx_serial_in;
      next_sync_b = sync_a;
   end

   // Two-flop synchroniser on the serial line, idle level out of reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
      end else begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
      end
   end

   // Mode decode: double speed only counts in asynchronous operation
   assign dbl        = double_speed_sel && !sync_mode;
   assign vote_first = dbl ? VOTE_FIRST_DBL : VOTE_FIRST_NORM;
   assign last_samp  = dbl ? LAST_SAMP_DBL : LAST_SAMP_NORM;
   assign in_vote    = (samp >= vote_first - 4'h1) && (samp <= vote_first + 4'h1);
   assign vote_bit   = (votes[0] & votes[1]) | (votes[0] & votes[2])
                     | (votes[1] & votes[2]);
   assign frame_bits = data_bits + {3'h0, parity_en};

   // Stop bit value and address marker
   assign stop_bit   = vote_bit;
   assign addr_flag  = (data_bits == 4'(DATA_BITS_MAX)) ? shreg[DATA_BITS_MAX-1] : stop_bit;
   assign keep_frame = !multiproc_filter_en || addr_flag;

   // ----------------------------------------------------------------------------
   // Receive sequencer
   // ----------------------------------------------------------------------------
   // Receive sequencer: next state
   always_comb begin
      next_state    = state;
      next_samp     = samp;
      next_bit_idx  = bit_idx;
      next_votes    = votes;
      next_shreg    = shreg;
      next_par      = par;
      next_lost     = lost;
      next_prev_hi  = prev_hi;
      fifo_in_valid = 1'b0;
      if (sample_tick) begin
         next_prev_hi = sync_b;
         case (state)
            UARX_IDLE: begin
               // Only a high-to-low step starts a frame, never a held low line
               if (!sync_b && prev_hi) begin
                  next_state = UARX_START;
                  next_samp  = 4'h1;
                  next_votes = 3'h0;
               end
            end
            UARX_START: begin
               next_samp = samp + 4'h1;
               if (in_vote) begin
                  next_votes = {votes[1:0], sync_b};
               end
               // Third vote sample is the live one; two highs of three mean noise
               if (samp == vote_first + 4'h1) begin
                  if (vote_bit || sync_b && (votes[0] | votes[1])) begin
                     next_state = UARX_IDLE;
                  end
               end
               if (samp == last_samp && state == UARX_START) begin
                  next_state   = UARX_BITS;
                  next_samp    = 4'h0;
                  next_bit_idx = 4'h0;
               end
            end
            UARX_BITS, UARX_STOP: begin
               next_samp = (samp == last_samp) ? 4'h0 : samp + 4'h1;
               if (in_vote) begin
                  next_votes = {votes[1:0], sync_b};
               end
               // Bit decided on the tick after its vote window closes
               if (samp == vote_first + 4'h2) begin
                  if (state == UARX_STOP) begin
                     // Frame complete after the last stop vote sample
                     if (keep_frame) begin
                        fifo_in_valid = 1'b1;
                        next_lost     = !fifo_in_ready;
                     end
                     next_state = UARX_IDLE;
                     // Normal speed takes a start on the sample after the stop vote
                     if (!dbl && stop_bit && !sync_b) begin
                        next_state = UARX_START;
                        next_samp  = 4'h1;
                        next_votes = 3'h0;
                     end
                  end else begin
                     if (bit_idx < data_bits) begin
                        next_shreg = {vote_bit, shreg[DATA_BITS_MAX-1:1]};
                     end else begin
                        next_par = vote_bit;
                     end
                     next_bit_idx = bit_idx + 4'h1;
                     if (bit_idx + 4'h1 == frame_bits) begin
                        next_state = UARX_STOP;
                     end
                  end
               end
            end
            default: begin
               next_state = UARX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state   <= UARX_IDLE;
         samp    <= 4'h0;
         bit_idx <= 4'h0;
         votes   <= 3'h0;
         shreg   <= '0;
         par     <= 1'b0;
         lost    <= 1'b0;
         prev_hi <= 1'b1;
      end else begin
         state   <= next_state;
         samp    <= next_samp;
         bit_idx <= next_bit_idx;
         votes   <= next_votes;
         shreg   <= next_shreg;
         par     <= next_par;
         lost    <= next_lost;
         prev_hi <= next_prev_hi;
      end
   end

   // ----------------------------------------------------------------------------
   // Frame buffer and outputs
   // ----------------------------------------------------------------------------
   // Frame word: data right-aligned, parity, frame error
   assign fifo_in_data = {!stop_bit, par,
                          shreg >> (4'(DATA_BITS_MAX) - data_bits)};

   uarx_fifo #(
      .WIDTH (WORD_W + 1),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (fifo_out_data)
   );

   // Output fields
   assign rx_data          = fifo_out_data[DATA_BITS_MAX-1:0];
   assign rx_parity        = fifo_out_data[DATA_BITS_MAX];
   assign frame_error_flag = fifo_out_data[WORD_W];
   assign frame_lost       = lost;
endmodule

`default_nettype wire

// File: inc/uarx_pkg.sv
// Package of constants and types for the asynchronous receive front end
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package uarx_pkg;

   localparam int         SAMPLES_NORMAL  = 16;
   localparam int         SAMPLES_DOUBLE  = 8;
   localparam logic [3:0] VOTE_FIRST_NORM = 4'h8;  // Samples 8, 9, 10
   localparam logic [3:0] VOTE_FIRST_DBL  = 4'h4;  // Samples 4, 5, 6
   localparam logic [3:0] LAST_SAMP_NORM  = 4'hF;  // Sample 16 as index 15
   localparam logic [3:0] LAST_SAMP_DBL   = 4'h7;  // Sample 8 as index 7
   localparam int         DATA_BITS_MAX   = 9;
   localparam int         FIFO_DEPTH      = 8;
   localparam int         WORD_W          = DATA_BITS_MAX + 1;  // Data plus parity; frame error sits at bit WORD_W

   typedef enum logic [3:0] {
      UARX_IDLE  = 4'b0001,
      UARX_START = 4'b0010,
      UARX_BITS  = 4'b0100,
      UARX_STOP  = 4'b1000
   } uarx_state_t;

endpackage

// File: verif/uarx_rx_checker.sv
// Port assertions for the asynchronous receive front end
`timescale 1ns/10ps
`default_nettype none
module uarx_rx_checker
   import uarx_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic                     clk_sys,
   input wire logic                     rst,
   input wire logic                     sample_tick,
   input wire logic                     rx_valid,
   input wire logic                     rx_ready,
   input wire logic [DATA_BITS_MAX-1:0] rx_data,
   input wire logic                     rx_parity,
   input wire logic                     frame_error_flag,
   input wire logic                     frame_lost
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Reset state and head word holding
   a_reset_clear: assert property (disable iff (1'b0) rst |=> !rx_valid && !frame_lost)
      else $error("flags set after reset");
   a_valid_holds: assert property (rx_valid && !rx_ready |=> rx_valid)
      else $error("word gone without a read");
   a_head_stable: assert property (rx_valid && !rx_ready |=>
      $stable(rx_data) && $stable(rx_parity) && $stable(frame_error_flag))
      else $error("head word changed while unread");
   a_pop_on_ready: assert property ($fell(rx_valid) |-> $past(rx_ready))
      else $error("emptied without a read");
   // Stores and loss marks follow sample ticks
   a_push_on_tick: assert property ($rose(rx_valid) |-> $past(sample_tick))
      else $error("word stored off a tick");
   a_lost_on_tick: assert property ($rose(frame_lost) |-> $past(sample_tick))
      else $error("loss marked off a tick");
   a_lost_if_full: assert property ($rose(frame_lost) |-> $past(rx_valid))
      else $error("loss marked with buffer empty");
   a_lost_clear: assert property ($fell(frame_lost) |-> rx_valid && $past(sample_tick))
      else $error("loss cleared without a stored word");
   // Main scenarios reached
   c_frame_err: cover property (rx_valid && frame_error_flag);
   c_lost: cover property (frame_lost);
   c_nine_bit: cover property (rx_valid && rx_ready && rx_data[8]);
endmodule
bind uarx_rx uarx_rx_checker #(.DEPTH(DEPTH)) u_chk (.clk_sys(clk_sys), .rst(rst),
   .sample_tick(sample_tick), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
   .rx_parity(rx_parity), .frame_error_flag(frame_error_flag), .frame_lost(frame_lost));
`default_nettype wire

// File: verif/uarx_tx_model.sv
// Behavioural remote serial transmitter on the receive line
`timescale 1ns/10ps
`default_nettype none
module uarx_tx_model (
   input  wire logic clk_sys,
   input  wire logic sample_tick,
   output var logic  line
);
   // Line idles high under its pull-up
   initial line = 1'b1;
   // Hold a level for n oversample ticks
   task automatic hold(input logic v, input int n);
      line <= v;
      repeat (n) begin
         @(posedge clk_sys);
         while (!sample_tick) @(posedge clk_sys);
      end
   endtask
   // Start, n bits LSB first, stop held sl ticks; g flips the first vote sample
   // Bit time equals the receiver's, inside both rate windows
   task automatic frame(input logic [9:0] b, input int n, input logic stop, input int spb,
                        input int sl, input logic g);
      hold(1'b0, spb);
      for (int i = 0; i < n; i++) begin
         hold(b[i], spb / 2 - 1);
         hold(b[i] ^ g, 1);
         hold(b[i], spb / 2);
      end
      hold(stop, sl);
   endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the asynchronous receive front end
`timescale 1ns/10ps
`default_nettype none
module tb
   import uarx_pkg::*;
;
   logic                     clk_sys, line, rx_valid, rx_parity, frame_error_flag, frame_lost;
   logic                     rst = 1'b1, sample_tick = 1'b0, ds = 1'b0, sm = 1'b0;
   logic                     filt = 1'b0, pe = 1'b0, rx_ready = 1'b0, rdy_en = 1'b0;
   logic [3:0]               data_bits = 4'h8;
   logic [DATA_BITS_MAX-1:0] rx_data;
   logic [31:0]              st = 32'h9F643EB4;
   logic [11:0]              q[$];
   int                       n_errors = 0, checks = 0, cyc = 0;

   uarx_rx DUT (.clk_sys(clk_sys), .rst(rst), .rx_serial_in(line),
      .sample_tick(sample_tick), .double_speed_sel(ds), .sync_mode(sm),
      .multiproc_filter_en(filt), .data_bits(data_bits), .parity_en(pe),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_parity(rx_parity),
      .frame_error_flag(frame_error_flag), .frame_lost(frame_lost));
   uarx_tx_model tx (.clk_sys(clk_sys), .sample_tick(sample_tick), .line(line));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp(input string nm, input logic [8:0] e, input logic [8:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Random frame; expected word queued unless filtered or lost
   task automatic sendf(input logic lost, input int spb);
      logic [8:0] d;
      logic [9:0] b;
      logic       stop, sh, p;
      int         nd;
      @(posedge clk_sys);
      nd = 5 + st[11:9] % 5;
      d = st[8:0] & 9'((1 << nd) - 1);
      stop = st[13] | st[16];
      sh = st[15] && spb == 16 && !lost;
      p = st[14];
      b = {1'b0, d};
      b[nd] = st[12];
      if (!lost && !(filt && !(nd == 9 ? d[8] : stop)))
         q.push_back({st[14], st[12], !stop, d});
      // Frame size changes only after the previous frame has been stored
      fork
         tx.frame(b, nd + 32'(p), stop, spb, sh ? 10 : spb, st[17]);
         begin
            repeat (8) @(posedge clk_sys);
            data_bits <= 4'(nd);
            pe <= p;
         end
      join
      if (!(sh && stop))
         tx.hold(1'b1, spb);
   endtask
   task automatic wait_empty();
      rdy_en <= 1'b1;
      for (int i = 0; i < 4000 && (q.size() > 0 || rx_valid); i++) @(posedge clk_sys);
      cmp("pending", 9'h000, 9'(q.size()));
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Tick every fourth clock, random reads, scoreboard, watchdog
   always @(posedge clk_sys) begin
      logic [11:0] e;
      st <= nxt(st);
      sample_tick <= cyc % 4 == 3;
      rx_ready <= rdy_en & st[3];
      cyc <= cyc + 1;
      if (!rst && rx_valid && rx_ready) begin
         e = q.size() > 0 ? q.pop_front() : 12'h1FF;
         cmp("data", e[8:0], rx_data);
         cmp("stop", {8'h00, e[9]}, {8'h00, frame_error_flag});
         if (e[11])
            cmp("parity", {8'h00, e[10]}, {8'h00, rx_parity});
      end
      if (cyc == 80000) begin
         n_errors++;
         conclude();
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      rdy_en <= 1'b1;
      // Normal, double speed, then double speed ignored in synchronous mode
      for (int m = 0; m < 3; m++) begin
         // Idle line so no frame is in flight when the mode changes
         tx.hold(1'b1, 16);
         ds <= m > 0;
         sm <= m == 2;
         repeat (8) sendf(1'b0, m == 1 ? 8 : 16);
      end
      ds <= 1'b0;
      sm <= 1'b0;
      // Noise pulse that ends before the vote window stores nothing
      tx.hold(1'b0, 7);
      tx.hold(1'b1, 16);
      filt <= 1'b1;
      repeat (10) sendf(1'b0, 16);
      tx.hold(1'b1, 16);
      filt <= 1'b0;
      wait_empty();
      // Fill past depth with reads stalled, then drain in order
      rdy_en <= 1'b0;
      for (int k = 0; k < 9; k++) sendf(k == 8, 16);
      repeat (40) @(posedge clk_sys);
      cmp("lost", 9'h001, {8'h00, frame_lost});
      wait_empty();
      sendf(1'b0, 16);
      wait_empty();
      cmp("lost", 9'h000, {8'h00, frame_lost});
      conclude();
   end
endmodule
`default_nettype wire
